// *** hdl/accel_temp_readout.sv ***
`timescale 1ns/1ps
`default_nettype none

//----------------------------------------------------------------------
// Serial readout of a dual-axis accelerometer with temperature sensor.
//----------------------------------------------------------------------
// The serial side runs on the serial clock, which stands still between
// frames. The temperature sequencer runs on the system clock. The two
// meet only through synchronisers and through the temperature result,
// which is frozen whenever the temperature select is low.
module accel_temp_readout import accel_temp_pkg::*; #(
  parameter int PERIOD_CYCLES = TEMP_PERIOD_CYCLES,
  parameter int CONV_CYCLES   = TEMP_CONV_CYCLES
) (
  // System clock and reset.
  input  wire logic               i_clock,
  input  wire logic               i_rst_n,
  // Serial link pins.
  input  wire logic               i_sclk,
  input  wire logic               i_accel_select_n,
  input  wire logic               i_temp_select_n,
  input  wire logic               i_din,
  output logic                    o_dout,
  output logic                    o_dout_oe,
  // Analog front end codes.
  input  wire logic [ACCEL_W-1:0] i_accel_x_code,
  input  wire logic [ACCEL_W-1:0] i_accel_y_code,
  input  wire logic [TEMP_W-1:0]  i_temp_code,
  // Status seen in the system domain.
  output logic                    o_accel_power_down,
  output logic                    o_axis_select_y,
  output logic                    o_temp_converting,
  output logic                    o_temp_lockout
);

  localparam int TIMER_W = $clog2(PERIOD_CYCLES + 1);
  localparam logic [TIMER_W-1:0] PERIOD_LAST = TIMER_W'(PERIOD_CYCLES - 1);
  localparam logic [TIMER_W-1:0] CONV_LAST   = TIMER_W'(CONV_CYCLES - 1);

  //--------------------------------------------------------------------
  // Serial domain: frame clears and counters.
  //--------------------------------------------------------------------

  logic             accel_idle;
  logic             temp_idle;
  logic             link_idle;
  logic [CNT_W-1:0] accel_cnt;
  logic [CNT_W-1:0] temp_cnt;

  // Each select clears its own frame logic while it is high.
  assign accel_idle = i_accel_select_n | ~i_rst_n;
  assign temp_idle  = i_temp_select_n | ~i_rst_n;
  assign link_idle  = (i_accel_select_n & i_temp_select_n) | ~i_rst_n;

  // Accelerometer edges wrap every sixteen clocks.
  serial_frame_counter #(
    .WIDTH    (CNT_W),
    .SATURATE (1'b0)
  ) u_accel_counter (
    .i_sclk  (i_sclk),
    .i_clear (accel_idle),
    .o_count (accel_cnt)
  );

  // Temperature edges hold at the top so the last bit stays.
  serial_frame_counter #(
    .WIDTH    (CNT_W),
    .SATURATE (1'b1)
  ) u_temp_counter (
    .i_sclk  (i_sclk),
    .i_clear (temp_idle),
    .o_count (temp_cnt)
  );

  //--------------------------------------------------------------------
  // Serial domain: analog codes brought onto the serial clock.
  //--------------------------------------------------------------------

  logic [ACCEL_W-1:0] accel_x_sync;
  logic [ACCEL_W-1:0] accel_y_sync;

  // The front end codes move slowly next to the sample rate.
  sync_2ff #(
    .WIDTH     (2 * ACCEL_W),
    .RESET_VAL ('0)
  ) u_accel_code_sync (
    .i_clock (i_sclk),
    .i_rst_n (i_rst_n),
    .i_async ({i_accel_y_code, i_accel_x_code}),
    .o_sync  ({accel_y_sync, accel_x_sync})
  );

  //--------------------------------------------------------------------
  // Serial domain: accelerometer control word.
  //--------------------------------------------------------------------

  logic [CTRL_W-1:0] ctrl_shift_ff;
  logic [CTRL_W-1:0] accel_ctrl_ff;
  logic [CTRL_W-1:0] nxt_ctrl_word;
  logic              power_down_ff;
  logic              wake_pending_ff;
  logic              ctrl_window;
  logic              ctrl_load;
  logic              frame_end;
  logic              new_power_down;

  // Control bits arrive on the first eight rising edges of each frame.
  assign ctrl_window    = (accel_cnt <= CTRL_LOAD_CNT);
  assign ctrl_load      = (accel_cnt == CTRL_LOAD_CNT);
  assign frame_end      = (accel_cnt == FRAME_END_CNT);
  assign nxt_ctrl_word  = {ctrl_shift_ff[CTRL_W-2:0], i_din};
  assign new_power_down = nxt_ctrl_word[POWER_DOWN_BIT];

  // Serial input shifts in on rising edges during the control window.
  always_ff @(posedge i_sclk or posedge accel_idle)
  begin
    if (accel_idle)
      ctrl_shift_ff <= '0;
    else if (ctrl_window)
      ctrl_shift_ff <= nxt_ctrl_word;
  end

  // The stored word survives frame ends and power-down alike.
  always_ff @(posedge i_sclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      accel_ctrl_ff <= ACCEL_CTRL_RESET;
    else if (!i_accel_select_n && ctrl_load)
      accel_ctrl_ff <= nxt_ctrl_word;
  end

  // Entering power-down is immediate, leaving waits for the frame end.
  always_ff @(posedge i_sclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      power_down_ff   <= 1'b0;
      wake_pending_ff <= 1'b0;
    end
    else if (!i_accel_select_n && ctrl_load && new_power_down)
    begin
      power_down_ff   <= 1'b1;
      wake_pending_ff <= 1'b0;
    end
    else if (!i_accel_select_n && ctrl_load && power_down_ff)
    begin
      wake_pending_ff <= 1'b1;
    end
    else if (!i_accel_select_n && frame_end && wake_pending_ff)
    begin
      power_down_ff   <= 1'b0;
      wake_pending_ff <= 1'b0;
    end
  end

  //--------------------------------------------------------------------
  // Serial domain: accelerometer sample.
  //--------------------------------------------------------------------

  logic [ACCEL_W-1:0] accel_sample_ff;
  logic [ACCEL_W-1:0] axis_code;
  logic               sample_now;

  // The stored axis bit picks which channel is converted.
  assign axis_code  = accel_ctrl_ff[AXIS_SELECT_BIT] ? accel_y_sync
                                                     : accel_x_sync;
  assign sample_now = (accel_cnt == SAMPLE_CNT);

  // Sampling repeats every frame while the select stays low.
  always_ff @(posedge i_sclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      accel_sample_ff <= '0;
    else if (!i_accel_select_n && sample_now)
      accel_sample_ff <= power_down_ff ? '0 : axis_code;
  end

  //--------------------------------------------------------------------
  // Serial domain: temperature shadow.
  //--------------------------------------------------------------------

  logic [TEMP_W-1:0] temp_result_ff;
  logic [TEMP_W-1:0] temp_shadow_ff;

  // The result is frozen by the system side while the select is low.
  always_ff @(posedge i_sclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      temp_shadow_ff <= '0;
    else if (!i_temp_select_n && temp_cnt == '0)
      temp_shadow_ff <= temp_result_ff;
  end

  //--------------------------------------------------------------------
  // Serial domain: data output on falling edges.
  //--------------------------------------------------------------------

  logic [FRAME_CYCLES-1:0] accel_word;
  logic [FRAME_CYCLES-1:0] temp_word;
  logic [CNT_W-1:0]        accel_idx;
  logic [CNT_W-1:0]        temp_idx;
  logic                    temp_window;
  logic                    nxt_dout;

  // Frames open with zeros so the first bit exists before any clock.
  assign accel_word  = {4'h0, accel_sample_ff};
  assign temp_word   = {temp_shadow_ff, 6'h00};
  assign accel_idx   = FRAME_END_CNT - accel_cnt;
  assign temp_idx    = 4'h0 - temp_cnt;
  assign temp_window = (temp_cnt != '0) && (temp_cnt <= TEMP_LAST_CNT);

  // Outside the temperature bit window the output keeps its level.
  assign nxt_dout = !i_accel_select_n ? accel_word[accel_idx]
                  : temp_window       ? temp_word[temp_idx]
                  :                     o_dout;

  // Clearing to zero at idle presents the leading zero of the next frame.
  always_ff @(negedge i_sclk or posedge link_idle)
  begin
    if (link_idle)
      o_dout <= 1'b0;
    else
      o_dout <= nxt_dout;
  end

  // The pin drives only while one of the selects is low.
  assign o_dout_oe = ~i_accel_select_n | ~i_temp_select_n;

  //--------------------------------------------------------------------
  // System domain: synchronised inputs.
  //--------------------------------------------------------------------

  logic              temp_sel_n_sync;
  logic [TEMP_W-1:0] temp_code_sync;

  // The select idles high so reset must not fake an access.
  sync_2ff #(
    .WIDTH     (1),
    .RESET_VAL (1'b1)
  ) u_temp_select_sync (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .i_async (i_temp_select_n),
    .o_sync  (temp_sel_n_sync)
  );

  // Sensor code from the analog converter.
  sync_2ff #(
    .WIDTH     (TEMP_W),
    .RESET_VAL ('0)
  ) u_temp_code_sync (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .i_async (i_temp_code),
    .o_sync  (temp_code_sync)
  );

  // Mode bits of the serial side shown as system status.
  sync_2ff #(
    .WIDTH     (2),
    .RESET_VAL (2'b00)
  ) u_mode_sync (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .i_async ({power_down_ff, accel_ctrl_ff[AXIS_SELECT_BIT]}),
    .o_sync  ({o_accel_power_down, o_axis_select_y})
  );

  //--------------------------------------------------------------------
  // System domain: temperature conversion sequencer.
  //--------------------------------------------------------------------

  temp_state_t      state_ff;
  temp_state_t      nxt_state;
  logic [TIMER_W-1:0] timer_ff;
  logic [TIMER_W-1:0] nxt_timer;
  logic             lockout_ff;
  logic             nxt_lockout;
  logic             sel_n_prev_ff;
  logic             access_on;
  logic             access_end;
  logic             period_done;
  logic             conv_done;
  logic             result_load;

  // Access tracking works from the synchronised select only.
  assign access_on   = ~temp_sel_n_sync;
  assign access_end  = temp_sel_n_sync & ~sel_n_prev_ff;
  assign period_done = (state_ff == ST_SLEEP) && (timer_ff == PERIOD_LAST);
  assign conv_done   = (state_ff == ST_CONVERT) && (timer_ff == CONV_LAST);
  assign result_load = conv_done && !nxt_lockout && !access_on;

  // Next state, timer and lockout of the sequencer.
  always_comb
  begin
    nxt_state   = state_ff;
    nxt_timer   = timer_ff + 1'b1;
    nxt_lockout = lockout_ff;
    if (access_end)
    begin
      nxt_state   = ST_CONVERT;
      nxt_timer   = '0;
      nxt_lockout = 1'b0;
    end
    else
    begin
      case (state_ff)
        ST_SLEEP:
        begin
          if (period_done)
          begin
            nxt_state   = ST_CONVERT;
            nxt_timer   = '0;
            nxt_lockout = access_on;
          end
        end
        ST_CONVERT:
        begin
          nxt_lockout = lockout_ff | access_on;
          if (conv_done)
          begin
            nxt_state = ST_SLEEP;
            nxt_timer = '0;
          end
        end
        default:
        begin
          nxt_state = ST_SLEEP;
          nxt_timer = '0;
        end
      endcase
    end
  end

  // Sequencer registers.
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_ff      <= ST_SLEEP;
      timer_ff      <= '0;
      lockout_ff    <= 1'b0;
      sel_n_prev_ff <= 1'b1;
    end
    else
    begin
      state_ff      <= nxt_state;
      timer_ff      <= nxt_timer;
      lockout_ff    <= nxt_lockout;
      sel_n_prev_ff <= temp_sel_n_sync;
    end
  end

  // A blocked conversion leaves the previous result in place, unless the synchronised select release falls on its last cycle.
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      temp_result_ff <= '0;
    else if (result_load)
      temp_result_ff <= temp_code_sync;
  end

  // Sequencer status.
  assign o_temp_converting = (state_ff == ST_CONVERT);
  assign o_temp_lockout    = lockout_ff;

endmodule

`default_nettype wire

// *** hdl/accel_temp_pkg.sv ***
//----------------------------------------------------------------------
// Shared constants of the dual-axis accelerometer and temperature readout.
//----------------------------------------------------------------------
//----------------------------------------------------------------------
package accel_temp_pkg;

  // Serial frame layout.
  localparam int FRAME_CYCLES   = 16;
  localparam int CNT_W          = 4;
  localparam int CTRL_W         = 8;
  localparam int ACCEL_W        = 12;
  localparam int TEMP_W         = 10;

  // Edge positions inside a frame, counted as edges already seen.
  localparam logic [3:0] SAMPLE_CNT    = 4'h1;
  localparam logic [3:0] CTRL_LOAD_CNT = 4'h7;
  localparam logic [3:0] FRAME_END_CNT = 4'hf;
  localparam logic [3:0] TEMP_LAST_CNT = 4'ha;

  // Accelerometer control word fields and reset value.
  localparam int AXIS_SELECT_BIT = 3;
  localparam int POWER_DOWN_BIT  = 0;
  localparam logic [7:0] ACCEL_CTRL_RESET = 8'h04;

  // Temperature conversion timing.
  localparam int CLOCK_MHZ      = 250;
  localparam int TEMP_PERIOD_US = 350;
  localparam int TEMP_CONV_US   = 25;
  localparam int TEMP_PERIOD_CYCLES = TEMP_PERIOD_US * CLOCK_MHZ;
  localparam int TEMP_CONV_CYCLES   = TEMP_CONV_US * CLOCK_MHZ;

  // Temperature sequencer states.
  typedef enum logic [0:0] {ST_SLEEP, ST_CONVERT} temp_state_t;

endpackage

// *** hdl/sync_2ff.sv ***
`timescale 1ns/1ps
`default_nettype none

//----------------------------------------------------------------------
// Two flip-flop synchroniser for levels entering a clock domain.
//----------------------------------------------------------------------
module sync_2ff #(
  parameter int             WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset.
  input  wire logic             i_clock,
  input  wire logic             i_rst_n,
  // Level in and out.
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_ff;

  // The first stage feeds only the second stage.
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      meta_ff <= RESET_VAL;
      o_sync  <= RESET_VAL;
    end
    else
    begin
      meta_ff <= i_async;
      o_sync  <= meta_ff;
    end
  end

endmodule

`default_nettype wire

// *** hdl/serial_frame_counter.sv ***
`timescale 1ns/1ps
`default_nettype none

//----------------------------------------------------------------------
// Counts rising serial clock edges inside a frame.
//----------------------------------------------------------------------
module serial_frame_counter #(
  parameter int WIDTH    = 4,
  parameter bit SATURATE = 1'b0
) (
  // Serial clock and frame clear, clear is active high.
  input  wire logic             i_sclk,
  input  wire logic             i_clear,
  // Edges seen so far, wrapping or holding at the top.
  output logic      [WIDTH-1:0] o_count
);

  logic             at_top;
  logic [WIDTH-1:0] nxt_count;

  // Wrap lets back-to-back frames restart; saturation holds the tail.
  assign at_top    = &o_count;
  assign nxt_count = (SATURATE && at_top) ? o_count : o_count + 1'b1;

  // The clear holds the count at zero while the frame is idle.
  always_ff @(posedge i_sclk or posedge i_clear)
  begin
    if (i_clear)
      o_count <= '0;
    else
      o_count <= nxt_count;
  end

endmodule

`default_nettype wire

// *** sim/accel_temp_readout_props.sv ***
`timescale 1ns/1ps
`default_nettype none

//----------------------------------------------------------------------
// Checker for the accelerometer and temperature readout.
//----------------------------------------------------------------------
module accel_temp_readout_props import accel_temp_pkg::*; #(
  parameter int PERIOD_CYCLES = 200,
  parameter int CONV_CYCLES   = 20
) (
  // Clocks and reset.
  input wire logic               i_clock,
  input wire logic               i_rst_n,
  input wire logic               i_sclk,
  // Serial pins.
  input wire logic               i_accel_select_n,
  input wire logic               i_temp_select_n,
  input wire logic               i_din,
  input wire logic               o_dout,
  input wire logic               o_dout_oe,
  // Front end codes and status.
  input wire logic [ACCEL_W-1:0] i_accel_x_code,
  input wire logic [ACCEL_W-1:0] i_accel_y_code,
  input wire logic [TEMP_W-1:0]  i_temp_code,
  input wire logic               o_accel_power_down,
  input wire logic               o_axis_select_y,
  input wire logic               o_temp_converting,
  input wire logic               o_temp_lockout
);
  logic [3:0]  acnt_ff;
  logic [3:0]  tcnt_ff;
  logic [3:0]  hist_ff;
  logic [31:0] ccnt_ff;
  logic [31:0] scnt_ff;
  logic        seen_ff;

  // Rising serial edges seen in the current frame of each select.
  always_ff @(posedge i_sclk or posedge i_accel_select_n)
    if (i_accel_select_n) acnt_ff <= '0;
    else acnt_ff <= acnt_ff + 4'h1;
  always_ff @(posedge i_sclk or posedge i_temp_select_n)
    if (i_temp_select_n) tcnt_ff <= '0;
    else tcnt_ff <= (tcnt_ff == 4'hf) ? tcnt_ff : tcnt_ff + 4'h1;

  // Run lengths of converting and sleeping, and recent temperature accesses.
  // A select release restarts the conversion, so it restarts the run count too.
  always_ff @(posedge i_clock or negedge i_rst_n)
    if (!i_rst_n)
    begin
      ccnt_ff <= '0;
      scnt_ff <= '0;
      hist_ff <= 4'hf;
      seen_ff <= 1'b0;
    end
    else
    begin
      ccnt_ff <= (o_temp_converting && !(i_temp_select_n && !hist_ff[0])) ? ccnt_ff + 1 : '0;
      scnt_ff <= o_temp_converting ? '0 : scnt_ff + 1;
      hist_ff <= {hist_ff[2:0], i_temp_select_n};
      seen_ff <= !i_temp_select_n || (seen_ff && !o_temp_converting);
    end

  a_oe_follows_select: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_dout_oe == (!i_accel_select_n || !i_temp_select_n)) else $error("enable mismatch");
  a_dout_idle_low: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_accel_select_n && i_temp_select_n) |-> !o_dout) else $error("idle output not low");
  a_accel_lead_zeros: assert property (@(posedge i_sclk)
    disable iff (!i_rst_n || i_accel_select_n)
    (acnt_ff < 4'h4) |-> !o_dout) else $error("accelerometer leading bit not zero");
  a_temp_lead_zero: assert property (@(posedge i_sclk)
    disable iff (!i_rst_n || i_temp_select_n)
    (tcnt_ff == 4'h0) |-> !o_dout) else $error("temperature leading bit not zero");
  a_temp_last_hold: assert property (@(posedge i_sclk)
    disable iff (!i_rst_n || i_temp_select_n)
    (tcnt_ff >= 4'hb) |-> $stable(o_dout)) else $error("last temperature bit not held");
  a_conv_length: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $fell(o_temp_converting) |-> ccnt_ff >= CONV_CYCLES && ccnt_ff <= CONV_CYCLES + 4)
    else $error("conversion length wrong");
  a_sleep_length: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $rose(o_temp_converting) |-> seen_ff
    || (scnt_ff >= PERIOD_CYCLES - 1 && scnt_ff <= PERIOD_CYCLES + 1))
    else $error("conversion started at wrong time");
  a_lock_clear: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $fell(o_temp_lockout) |-> o_temp_converting && i_temp_select_n)
    else $error("lockout cleared outside conversion start");
  a_lock_set: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $rose(o_temp_lockout) |-> o_temp_converting && hist_ff != 4'hf)
    else $error("lockout set without access in conversion");
endmodule

bind accel_temp_readout accel_temp_readout_props #(
  .PERIOD_CYCLES(PERIOD_CYCLES), .CONV_CYCLES(CONV_CYCLES)
) u_props (
  .i_clock(i_clock), .i_rst_n(i_rst_n), .i_sclk(i_sclk),
  .i_accel_select_n(i_accel_select_n), .i_temp_select_n(i_temp_select_n),
  .i_din(i_din), .o_dout(o_dout), .o_dout_oe(o_dout_oe),
  .i_accel_x_code(i_accel_x_code), .i_accel_y_code(i_accel_y_code),
  .i_temp_code(i_temp_code), .o_accel_power_down(o_accel_power_down),
  .o_axis_select_y(o_axis_select_y), .o_temp_converting(o_temp_converting),
  .o_temp_lockout(o_temp_lockout)
);

`default_nettype wire

// *** sim/spi_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

//----------------------------------------------------------------------
// Host serial controller that frames accelerometer and temperature transfers.
//----------------------------------------------------------------------
module spi_host_model (
  // System clock used to place select edges.
  input  wire logic i_clock,
  // Serial pins.
  input  wire logic i_dout,
  output logic      o_sclk,
  output logic      o_accel_select_n,
  output logic      o_temp_select_n,
  output logic      o_din
);
  // Pins idle with the clock still and both selects high.
  initial
  begin
    o_sclk = 1'b0;
    o_accel_select_n = 1'b1;
    o_temp_select_n = 1'b1;
    o_din = 1'b0;
  end

  // Runs n serial clocks, data in MSB first, data out taken at each rise.
  task automatic clocks(input int n, input logic [15:0] tx, output logic [15:0] rx);
    #1.3;
    for (int k = 0; k < n; k++)
    begin
      o_din = tx[15 - (k % 16)];
      #3 o_sclk = 1'b1;
      rx = {rx[14:0], i_dout};
      #3 o_sclk = 1'b0;
    end
  endtask

  // Whole accelerometer frames with one control word; only one select is low.
  // Frames come faster than the analog settling limit, which the logic never sees.
  task automatic accel(input logic [7:0] ctl, input int nf, output logic [15:0] rx);
    @(negedge i_clock) o_accel_select_n = 1'b0;
    clocks(16 * nf, {ctl, 8'h00}, rx);
    @(negedge i_clock) o_accel_select_n = 1'b1;
    #1;
  endtask

  // Temperature read with data in held low; the select stays low afterwards.
  task automatic temp_read(output logic [15:0] rx);
    @(negedge i_clock) o_temp_select_n = 1'b0;
    clocks(16, 16'h0000, rx);
  endtask

  task automatic temp_release();
    @(negedge i_clock) o_temp_select_n = 1'b1;
    #1;
  endtask
endmodule

`default_nettype wire

// *** sim/tb.sv ***
`timescale 1ns/1ps
`default_nettype none

//----------------------------------------------------------------------
// Self-checking bench for the accelerometer and temperature readout.
//----------------------------------------------------------------------
module tb import accel_temp_pkg::*;;
  localparam int PERIOD = 200;
  localparam int CONV   = 20;
  localparam logic [ACCEL_W-1:0] X_CODE = 12'h123;
  localparam logic [ACCEL_W-1:0] Y_CODE = 12'habc;
  logic        i_clock;
  logic        i_rst_n;
  logic        sclk;
  logic        accel_select_n;
  logic        temp_select_n;
  logic        din;
  logic        dout;
  logic        dout_oe;
  logic        power_down;
  logic        axis_y;
  logic        converting;
  logic        lockout;
  logic [9:0]  t_code;
  logic [15:0] rx;
  int          n_fail = 0;
  int          check_count = 0;
  int          cycles = 0;
  int          highs;

  accel_temp_readout #(.PERIOD_CYCLES(PERIOD), .CONV_CYCLES(CONV)) u_accel_temp_readout (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_sclk(sclk),
    .i_accel_select_n(accel_select_n), .i_temp_select_n(temp_select_n),
    .i_din(din), .o_dout(dout), .o_dout_oe(dout_oe),
    .i_accel_x_code(X_CODE), .i_accel_y_code(Y_CODE), .i_temp_code(t_code),
    .o_accel_power_down(power_down), .o_axis_select_y(axis_y),
    .o_temp_converting(converting), .o_temp_lockout(lockout));

  // A pin left undriven reads as the opposite level, so a sample outside the drive shows.
  spi_host_model u_spi_host_model (
    .i_clock(i_clock), .i_dout(dout_oe ? dout : ~dout), .o_sclk(sclk),
    .o_accel_select_n(accel_select_n),
    .o_temp_select_n(temp_select_n), .o_din(din));

  // Compares one value and counts the outcome.
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      n_fail++;
    end
  endtask

  // Waits, bounded, for the converting flag to reach a level.
  task automatic wait_conv(input logic lvl);
    for (int i = 0; i < 1000 && converting !== lvl; i++)
      @(negedge i_clock);
    if (converting !== lvl)
    begin
      $display("wrong value converting expected %h seen %h", lvl, converting);
      n_fail++;
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always #2 i_clock = ~i_clock;

  // Cuts a hung run short.
  always @(posedge i_clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_fail++;
      end_of_test();
    end
  end

  // Accelerometer frames first, then temperature reads and conversions.
  initial
  begin
    i_clock = 1'b0;
    i_rst_n = 1'b0;
    t_code = 10'h3d5;
    repeat (2) @(negedge i_clock);
    i_rst_n = 1'b1;
    repeat (2) @(negedge i_clock);
    u_spi_host_model.accel(8'h0c, 1, rx);
    u_spi_host_model.accel(8'h84, 1, rx);
    check("y sample", {4'h0, Y_CODE}, rx);
    repeat (5) @(negedge i_clock);
    check("axis x", 16'h0000, {15'h0, axis_y});
    u_spi_host_model.accel(8'h05, 1, rx);
    check("x sample", {4'h0, X_CODE}, rx);
    repeat (5) @(negedge i_clock);
    check("power down", 16'h0001, {15'h0, power_down});
    check("axis kept", 16'h0000, {15'h0, axis_y});
    u_spi_host_model.accel(8'h0c, 1, rx);
    check("down sample", 16'h0000, rx);
    repeat (5) @(negedge i_clock);
    check("woken", 16'h0000, {15'h0, power_down});
    check("axis y", 16'h0001, {15'h0, axis_y});
    u_spi_host_model.accel(8'h04, 2, rx);
    check("chained", {4'h0, X_CODE}, rx);
    check("released", 16'h0000, {14'h0, dout_oe, dout});
    repeat (150) @(negedge i_clock);
    u_spi_host_model.temp_read(rx);
    check("temp first", {1'b0, 10'h3d5, 5'h1f}, rx);
    check("temp hold oe", 16'h0001, {15'h0, dout_oe});
    u_spi_host_model.temp_release();
    t_code = 10'h028;
    repeat (4) @(negedge i_clock);
    u_spi_host_model.temp_read(rx);
    check("temp repeat", {1'b0, 10'h3d5, 5'h1f}, rx);
    check("lockout", 16'h0001, {15'h0, lockout});
    u_spi_host_model.temp_release();
    repeat (CONV + 20) @(negedge i_clock);
    u_spi_host_model.temp_read(rx);
    check("temp restart", {1'b0, 10'h028, 5'h00}, rx);
    u_spi_host_model.temp_release();
    check("temp release", 16'h0000, {15'h0, dout_oe});
    wait_conv(1'b1);
    wait_conv(1'b0);
    t_code = 10'h200;
    highs = 0;
    repeat (PERIOD + CONV)
    begin
      @(negedge i_clock);
      highs += int'(converting === 1'b1);
    end
    check("conversion cycles", 16'(CONV), 16'(highs));
    u_spi_host_model.temp_read(rx);
    check("temp periodic", {1'b0, 10'h200, 5'h00}, rx);
    u_spi_host_model.temp_release();
    end_of_test();
  end
endmodule

`default_nettype wire
